// ===== hdl/bldc_guard_pkg.sv
package bldc_guard_pkg;

  // Clock and derived timing.
  localparam int CLK_HZ = 50_000_000;
  localparam int MAX_ELEC_HZ = 3000;
  // Longest electrical period that still counts as overspeed, rounded down.
  localparam int OVF_PERIOD_CYC = CLK_HZ / MAX_ELEC_HZ;
  localparam int ADV_STEP_US = 20;
  localparam int ADV_STEP_CYC = (ADV_STEP_US * CLK_HZ) / 1_000_000;
  localparam int STUCK_CYCLES = 2;
  localparam int ILIM_STEP_MA = 125;
  // Low-side surge clamp time, counted in advance steps.
  localparam logic [15:0] SURGE_TICKS = 16'h0005;

  // Register byte offsets.
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_QUAL = 8'h04;
  localparam logic [7:0] OFS_LOCKOFF = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_MASK = 8'h10;
  localparam logic [7:0] OFS_STATE = 8'h14;
  localparam logic [7:0] OFS_KT = 8'h18;

  // Field positions and widths.
  localparam int ILIM_LSB = 0;
  localparam int ILIM_W = 3;
  localparam int ADV_LSB = 3;
  localparam int ADV_W = 5;
  localparam int NUM_EV = 6;
  localparam int EV_FREQ = 0;
  localparam int EV_KT = 1;
  localparam int EV_BEMF = 2;
  localparam int EV_STUCK = 3;
  localparam int EV_SHORT = 4;
  localparam int EV_LIMIT = 5;

  // Reset values.
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [15:0] QUAL_RST = 16'h0064;
  localparam logic [15:0] LOCKOFF_RST = 16'h0FA0;
  localparam logic [NUM_EV-1:0] MASK_RST = 6'h00;

  // Drive supervisor states, Gray coded along run, surge, off, short.
  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_SURGE = 2'b01,
    ST_OFF = 2'b11,
    ST_SHORT = 2'b10
  } drive_state_t;

  // Saturating scaled product; used for back-EMF and resistive drop.
  function automatic logic [15:0] mul_sat(input logic [15:0] a,
                                          input logic [15:0] b,
                                          input int unsigned sh);
    logic [31:0] p;
    p = ({16'h0000, a} * {16'h0000, b}) >> sh;
    return (p > 32'h0000FFFF) ? 16'hFFFF : p[15:0];
  endfunction

  // Saturating sum, so an overflow never wraps to a tiny amplitude.
  function automatic logic [15:0] add_sat(input logic [15:0] a,
                                          input logic [15:0] b);
    logic [16:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[16] ? 16'hFFFF : s[15:0];
  endfunction

endpackage

// ===== hdl/advance_timer.sv
`timescale 1ns/1ps
// Schedules the next commutation ahead of the expected back-EMF edge.
module advance_timer (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic tick,
  input wire logic zero_cross,
  input wire logic [4:0] advance_angle_code,
  output logic comm
);

  logic [15:0] elapsed_q;
  logic [15:0] period_q;
  logic armed_q;
  logic comm_q;
  logic [15:0] target_w;
  logic fire_w;

  // Target is one period minus the advance, clamped at zero.
  always_comb begin
    if (period_q > {11'h000, advance_angle_code}) begin
      target_w = period_q - {11'h000, advance_angle_code};
    end else begin
      target_w = 16'h0000;
    end
    fire_w = armed_q && !zero_cross && (elapsed_q >= target_w);
  end

  // Period is measured in advance steps between zero crossings.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      elapsed_q <= 16'h0000;
      period_q <= 16'h0000;
    end else if (zero_cross) begin
      period_q <= elapsed_q;
      elapsed_q <= 16'h0000;
    end else if (tick && elapsed_q != 16'hFFFF) begin
      elapsed_q <= elapsed_q + 16'h0001;
    end
  end

  // One commutation pulse per crossing; re-armed by the next crossing.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      armed_q <= 1'b0;
      comm_q <= 1'b0;
    end else begin
      comm_q <= fire_w;
      if (zero_cross) begin
        armed_q <= 1'b1;
      end else if (fire_w) begin
        armed_q <= 1'b0;
      end
    end
  end

  assign comm = comm_q;

  adv_fire_a: assert property (@(posedge pclk) disable iff (!presetn)
    fire_w |=> comm && !armed_q)
    else $error("advanced commutation not issued at target");

  adv_seen_c: cover property (@(posedge pclk) disable iff (!presetn)
    zero_cross ##[1:300] comm);

endmodule

// ===== hdl/bldc_lock_and_surge_protect.sv
// Added by the designer: the APB register port and the register addresses.
`timescale 1ns/1ps
// Summary of operation
// - Closed loop above 3 kHz is a lock.
// - Learn constant at start, set bounds.
// - Live constant outside bounds is a lock.
// - Back-EMF over amplitude for qual time locks.
// - Open loop, no crossing for two cycles.
// - Closed loop: clamp amplitude to limit drop plus back-EMF.
// - Code zero off, else 125 mA steps.
// - Short circuit puts all phases high-impedance.
// - After short clears, reinitialise and restart.
// - Rate-limit the speed command, mostly downward.
// - Keep amplitude above computed back-EMF in closed loop.
// - On lock stop, low-side switch returns winding current.
// - Advance drive by code times 20 us.
// - Lock stops drive, then retries after delay.
module bldc_lock_and_surge_protect #(
  parameter int OVF_PERIOD = bldc_guard_pkg::OVF_PERIOD_CYC,
  parameter int KT_SHIFT = 8,
  parameter int RM_SHIFT = 8,
  parameter int KT_TOL_SHIFT = 2,
  parameter logic [15:0] RAMP_UP_STEP = 16'h0040,
  parameter logic [15:0] RAMP_DN_STEP = 16'h0008
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  input wire logic closed_loop,
  input wire logic open_loop,
  input wire logic above_handoff,
  input wire logic elec_tick,
  input wire logic zero_cross,
  input wire logic kt_learn,
  input wire logic [15:0] bemf_integral,
  input wire logic kt_live_valid,
  input wire logic [15:0] kt_live,
  input wire logic [15:0] speed,
  input wire logic [15:0] speed_cmd,
  input wire logic [15:0] motor_resistance,
  input wire logic short_circuit_threshold,
  output logic drive_en,
  output logic low_side_switch,
  output logic [15:0] amplitude,
  output logic comm_advance,
  output logic restart_req,
  output logic init_req
);

  bldc_guard_pkg::drive_state_t state_q, state_d;
  logic [7:0] ctrl_q;
  logic [15:0] qual_q, lockoff_q, wait_q, tick_cnt_q, qual_cnt_q;
  logic [bldc_guard_pkg::NUM_EV-1:0] status_q, mask_q, ev_w, w1c_w;
  logic [31:0] prdata_q, rd_w;
  logic pready_q, pslverr_q, irq_q, tick_q, addr_ok_w, wr_w;
  logic [16:0] per_cnt_q;
  logic [1:0] ol_cyc_q;
  logic [15:0] bemf_constant, bemf_const_lower_bound, bemf_const_upper_bound;
  logic kt_valid_q;
  logic [15:0] bemf_q, ramp_q, amp_q, lim_w, floor_w, dem_w, ilim_ma_w;
  logic limit_on_w, limiting_w, limiting_q, bemf_over_w, run_w;
  logic lock_freq_w, lock_kt_w, lock_bemf_w, lock_stuck_w, lock_evt_w;
  logic drive_en_q, low_side_q, restart_q, init_q;
  logic [2:0] current_limit_code;
  logic [4:0] advance_angle_code;

  assign current_limit_code = ctrl_q[bldc_guard_pkg::ILIM_LSB +:
                                     bldc_guard_pkg::ILIM_W];
  assign advance_angle_code = ctrl_q[bldc_guard_pkg::ADV_LSB +:
                                     bldc_guard_pkg::ADV_W];
  assign run_w = (state_q == bldc_guard_pkg::ST_RUN);

  // Divider giving one pulse per advance step; also paces ramps and waits.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_q <= 16'h0000;
      tick_q <= 1'b0;
    end else if (tick_cnt_q == 16'(bldc_guard_pkg::ADV_STEP_CYC - 1)) begin
      tick_cnt_q <= 16'h0000;
      tick_q <= 1'b1;
    end else begin
      tick_cnt_q <= tick_cnt_q + 16'h0001;
      tick_q <= 1'b0;
    end
  end

  // APB decode: one wait-free access phase, pready registered in setup.
  always_comb begin
    addr_ok_w = 1'b1;
    rd_w = 32'h0000_0000;
    case (paddr)
      bldc_guard_pkg::OFS_CTRL: rd_w = {24'h000000, ctrl_q};
      bldc_guard_pkg::OFS_QUAL: rd_w = {16'h0000, qual_q};
      bldc_guard_pkg::OFS_LOCKOFF: rd_w = {16'h0000, lockoff_q};
      bldc_guard_pkg::OFS_STATUS: rd_w = {26'h0, status_q};
      bldc_guard_pkg::OFS_MASK: rd_w = {26'h0, mask_q};
      bldc_guard_pkg::OFS_STATE:
        rd_w = {28'h0000000, limiting_q, kt_valid_q, state_q};
      bldc_guard_pkg::OFS_KT:
        rd_w = {bemf_const_upper_bound, bemf_constant};
      default: addr_ok_w = 1'b0;
    endcase
  end

  assign wr_w = psel && penable && pready_q && pwrite && !pslverr_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= psel && !penable;
      pslverr_q <= psel && !penable && !addr_ok_w;
      if (psel && !penable) begin
        prdata_q <= rd_w;
      end
    end
  end

  // Software-written configuration; this steers the limit and advance.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= bldc_guard_pkg::CTRL_RST;
      qual_q <= bldc_guard_pkg::QUAL_RST;
      lockoff_q <= bldc_guard_pkg::LOCKOFF_RST;
      mask_q <= bldc_guard_pkg::MASK_RST;
    end else if (wr_w) begin
      case (paddr)
        bldc_guard_pkg::OFS_CTRL: ctrl_q <= pwdata[7:0];
        bldc_guard_pkg::OFS_QUAL: qual_q <= pwdata[15:0];
        bldc_guard_pkg::OFS_LOCKOFF: lockoff_q <= pwdata[15:0];
        bldc_guard_pkg::OFS_MASK: mask_q <= pwdata[5:0];
        default: ;
      endcase
    end
  end

  // Sticky status; a new event in the clearing cycle wins over the clear.
  assign w1c_w = (wr_w && paddr == bldc_guard_pkg::OFS_STATUS) ?
                 pwdata[5:0] : 6'h00;
  assign ev_w = {limiting_w && !limiting_q,
                 short_circuit_threshold && state_q != bldc_guard_pkg::ST_SHORT,
                 lock_stuck_w, lock_bemf_w, lock_kt_w, lock_freq_w};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_q <= 6'h00;
      irq_q <= 1'b0;
    end else begin
      status_q <= (status_q & ~w1c_w) | ev_w;
      irq_q <= |(status_q & mask_q);
    end
  end

  // Electrical period in clock cycles; saturated until the next run.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      per_cnt_q <= 17'h1FFFF;
    end else if (!run_w) begin
      per_cnt_q <= 17'h1FFFF;
    end else if (elec_tick) begin
      per_cnt_q <= 17'h00000;
    end else if (per_cnt_q != 17'h1FFFF) begin
      per_cnt_q <= per_cnt_q + 17'h00001;
    end
  end

  assign lock_freq_w = closed_loop && run_w && elec_tick &&
                       (per_cnt_q < 17'(OVF_PERIOD));

  // Constant learned on each kt_learn pulse except in an init_q cycle, bounds placed around it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bemf_constant <= 16'h0000;
      bemf_const_lower_bound <= 16'h0000;
      bemf_const_upper_bound <= 16'hFFFF;
      kt_valid_q <= 1'b0;
    end else if (init_q) begin
      kt_valid_q <= 1'b0;
    end else if (kt_learn) begin
      bemf_constant <= bemf_integral;
      bemf_const_lower_bound <= bemf_integral - (bemf_integral >> KT_TOL_SHIFT);
      bemf_const_upper_bound <= bldc_guard_pkg::add_sat(bemf_integral,
                                  bemf_integral >> KT_TOL_SHIFT);
      kt_valid_q <= 1'b1;
    end
  end

  assign lock_kt_w = closed_loop && run_w && kt_valid_q && kt_live_valid &&
                     (kt_live < bemf_const_lower_bound ||
                      kt_live > bemf_const_upper_bound);

  // Open-loop stuck: electrical cycles seen since the last zero crossing.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ol_cyc_q <= 2'h0;
    end else if (zero_cross || !open_loop || !run_w) begin
      ol_cyc_q <= 2'h0;
    end else if (elec_tick && above_handoff && ol_cyc_q != 2'h3) begin
      ol_cyc_q <= ol_cyc_q + 2'h1;
    end
  end

  assign lock_stuck_w = open_loop && above_handoff && run_w && elec_tick &&
                        !zero_cross &&
                        ol_cyc_q == 2'(bldc_guard_pkg::STUCK_CYCLES - 1);

  // Back-EMF estimate from speed and the learned constant.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bemf_q <= 16'h0000;
    end else begin
      bemf_q <= bldc_guard_pkg::mul_sat(speed, bemf_constant, KT_SHIFT);
    end
  end

  // Soft limit and surge floor; the limit never raises a fault itself.
  always_comb begin
    ilim_ma_w = 16'(current_limit_code) *
                16'(bldc_guard_pkg::ILIM_STEP_MA);
    lim_w = bldc_guard_pkg::add_sat(
              bldc_guard_pkg::mul_sat(ilim_ma_w, motor_resistance, RM_SHIFT),
              bemf_q);
    floor_w = bldc_guard_pkg::add_sat(bemf_q, 16'h0001);
    limit_on_w = closed_loop && run_w && current_limit_code != 3'h0;
    limiting_w = limit_on_w && (ramp_q > lim_w);
    dem_w = limiting_w ? lim_w : ramp_q;
    bemf_over_w = closed_loop && run_w && (bemf_q > dem_w);
  end

  // Buffered command slews slowly downward so the rotor cannot regenerate.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ramp_q <= 16'h0000;
    end else if (tick_q) begin
      if (speed_cmd > ramp_q) begin
        ramp_q <= (speed_cmd - ramp_q > RAMP_UP_STEP) ?
                  ramp_q + RAMP_UP_STEP : speed_cmd;
      end else if (speed_cmd < ramp_q) begin
        ramp_q <= (ramp_q - speed_cmd > RAMP_DN_STEP) ?
                  ramp_q - RAMP_DN_STEP : speed_cmd;
      end
    end
  end

  // Applied amplitude: zero when not driving, floored above back-EMF in closed loop.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      amp_q <= 16'h0000;
      limiting_q <= 1'b0;
    end else begin
      limiting_q <= limiting_w;
      if (!run_w) begin
        amp_q <= 16'h0000;
      end else if (closed_loop && dem_w < floor_w) begin
        amp_q <= floor_w;
      end else begin
        amp_q <= dem_w;
      end
    end
  end

  // Demanded amplitude below back-EMF for the qualification time locks.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      qual_cnt_q <= 16'h0000;
    end else if (!bemf_over_w) begin
      qual_cnt_q <= 16'h0000;
    end else if (tick_q && qual_cnt_q != 16'hFFFF) begin
      qual_cnt_q <= qual_cnt_q + 16'h0001;
    end
  end

  assign lock_bemf_w = bemf_over_w && (qual_cnt_q >= qual_q);
  assign lock_evt_w = lock_freq_w || lock_kt_w || lock_bemf_w ||
                      lock_stuck_w;

  // Supervisor; a short overrides everything, even a surge clamp.
  always_comb begin
    state_d = state_q;
    if (short_circuit_threshold &&
        state_q != bldc_guard_pkg::ST_SHORT) begin
      state_d = bldc_guard_pkg::ST_SHORT;
    end else begin
      case (state_q)
        bldc_guard_pkg::ST_RUN:
          if (lock_evt_w) state_d = bldc_guard_pkg::ST_SURGE;
        bldc_guard_pkg::ST_SURGE:
          if (tick_q && wait_q == bldc_guard_pkg::SURGE_TICKS - 16'h0001)
            state_d = bldc_guard_pkg::ST_OFF;
        bldc_guard_pkg::ST_OFF:
          if (wait_q >= lockoff_q) state_d = bldc_guard_pkg::ST_RUN;
        bldc_guard_pkg::ST_SHORT:
          if (!short_circuit_threshold) state_d = bldc_guard_pkg::ST_RUN;
        default: state_d = bldc_guard_pkg::ST_RUN;
      endcase
    end
  end

  // Wait counter in advance steps, restarted on every state change.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= bldc_guard_pkg::ST_RUN;
      wait_q <= 16'h0000;
    end else begin
      state_q <= state_d;
      if (state_d != state_q) begin
        wait_q <= 16'h0000;
      end else if (tick_q && wait_q != 16'hFFFF) begin
        wait_q <= wait_q + 16'h0001;
      end
    end
  end

  // Phase controls follow the next state so the stop lands in the same cycle as state_q.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drive_en_q <= 1'b0;
      low_side_q <= 1'b0;
      restart_q <= 1'b0;
      init_q <= 1'b0;
    end else begin
      drive_en_q <= (state_d == bldc_guard_pkg::ST_RUN);
      low_side_q <= (state_d == bldc_guard_pkg::ST_SURGE);
      restart_q <= (state_q == bldc_guard_pkg::ST_OFF) &&
                   (state_d == bldc_guard_pkg::ST_RUN);
      init_q <= (state_q == bldc_guard_pkg::ST_SHORT) &&
                (state_d == bldc_guard_pkg::ST_RUN);
    end
  end

  advance_timer u_adv (
    .pclk(pclk),
    .presetn(presetn),
    .tick(tick_q),
    .zero_cross(zero_cross),
    .advance_angle_code(advance_angle_code),
    .comm(comm_advance)
  );

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign irq = irq_q;
  assign drive_en = drive_en_q;
  assign low_side_switch = low_side_q;
  assign amplitude = amp_q;
  assign restart_req = restart_q;
  assign init_req = init_q;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  freq_lock_a: assert property (lock_freq_w && !short_circuit_threshold
    |=> state_q == bldc_guard_pkg::ST_SURGE ##1 low_side_switch)
    else $error("overspeed did not start the stop sequence");
  kt_learn_a: assert property (kt_learn && !init_q |=> kt_valid_q &&
    bemf_const_lower_bound <= bemf_constant &&
    bemf_const_upper_bound >= bemf_constant)
    else $error("learned constant outside its own bounds");
  kt_lock_a: assert property (lock_kt_w && !short_circuit_threshold
    |=> !run_w ##1 !drive_en)
    else $error("constant out of range did not stop drive");
  bemf_lock_a: assert property (bemf_over_w && qual_cnt_q >= qual_q &&
    !short_circuit_threshold |=> state_q == bldc_guard_pkg::ST_SURGE)
    else $error("back-EMF over amplitude not qualified as lock");
  stuck_lock_a: assert property (lock_stuck_w && !short_circuit_threshold
    |=> !run_w)
    else $error("open-loop stuck not detected");
  limit_clamp_a: assert property (limiting_w && lim_w >= floor_w
    |=> amplitude == $past(lim_w))
    else $error("soft limit did not clamp amplitude");
  limit_quiet_a: assert property (limiting_w && !lock_evt_w &&
    !short_circuit_threshold |=> run_w)
    else $error("soft limit stopped the motor");
  short_hiz_a: assert property (short_circuit_threshold
    |=> !drive_en && !low_side_switch)
    else $error("short did not float all phases");
  short_init_a: assert property (state_q == bldc_guard_pkg::ST_SHORT &&
    !short_circuit_threshold |=> init_req ##1 !kt_valid_q)
    else $error("short recovery skipped initialisation");
  ramp_rate_a: assert property (1'b1 |=>
    {1'b0, ramp_q} + {1'b0, RAMP_DN_STEP} >= {1'b0, $past(ramp_q)})
    else $error("command fell faster than the slew limit");
  surge_floor_a: assert property (run_w && closed_loop
    |=> amplitude >= $past(floor_w))
    else $error("amplitude fell to back-EMF");
  surge_clamp_a: assert property (state_q == bldc_guard_pkg::ST_SURGE &&
    !short_circuit_threshold |-> low_side_switch && !drive_en)
    else $error("low side not on while winding current decays");
  retry_a: assert property (state_q == bldc_guard_pkg::ST_OFF &&
    state_d == bldc_guard_pkg::ST_RUN |=> restart_req && drive_en)
    else $error("retry after lock-off delay missing");

  lock_stop_c: cover property (lock_evt_w ##1 !run_w ##1 low_side_switch);
  short_recover_c: cover property (short_circuit_threshold ##1
    !short_circuit_threshold ##1 init_req);
  limit_c: cover property (limiting_w && closed_loop);

endmodule

// ===== test/motor_model.sv
`timescale 1ns/1ps
// Windings behind the power stage: one electrical cycle every period + 1 clocks while
// driven, and back-EMF crossings only while the rotor really turns.
module motor_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic drive_en,
  input wire logic turning,
  input wire logic [15:0] period,
  output logic elec_tick,
  output logic zero_cross
);
  logic [15:0] cnt_q;
  // An undriven or stalled rotor gives no crossing, which is the hazard.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 16'h0000;
      elec_tick <= 1'b0;
      zero_cross <= 1'b0;
    end else begin
      elec_tick <= drive_en && (cnt_q == period);
      zero_cross <= drive_en && turning && (cnt_q == period);
      cnt_q <= (cnt_q >= period) ? 16'h0000 : cnt_q + 16'h0001;
    end
  end
endmodule

// ===== test/testbench.sv
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin \
  err_total++; $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
`define WAITC(c) begin n = 0; while (!(c) && n < 30000) begin \
  @(posedge pclk); n++; end if (n >= 30000) test_done(1); end
module testbench;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic closed_loop, open_loop, above_handoff, elec_tick, zero_cross;
  logic kt_learn, kt_live_valid, short_circuit_threshold, turning;
  logic [15:0] bemf_integral, kt_live, speed, speed_cmd;
  logic [15:0] motor_resistance, amplitude, period;
  logic drive_en, low_side_switch, comm_advance, restart_req, init_req;
  logic [32:0] expq[$];
  logic [32:0] e_v;
  int err_total = 0, num_checks = 0, n;
  logic [4:0] adv;
  time t0;
  bldc_lock_and_surge_protect #(.OVF_PERIOD(50)) dut (.pclk, .presetn,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .irq, .closed_loop, .open_loop, .above_handoff,
    .elec_tick, .zero_cross, .kt_learn, .bemf_integral, .kt_live_valid,
    .kt_live, .speed, .speed_cmd, .motor_resistance,
    .short_circuit_threshold, .drive_en, .low_side_switch, .amplitude,
    .comm_advance, .restart_req, .init_req);
  motor_model windings (.pclk, .presetn, .drive_en, .turning, .period,
    .elec_tick, .zero_cross);
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  task automatic test_done(input bit to);
    if (to) err_total++;
    $display("checks=%0d errors=%0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // One APB transfer; a read leaves its expected {pslverr, prdata}.
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, input logic [32:0] e);
    int k;
    if (!wr) expq.push_back(e);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin @(posedge pclk); k++; end while (!pready && k < 50);
    if (!pready) test_done(1);
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask
  // Read results are matched in order against the oldest expectation.
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite) begin
      if (expq.size() == 0) test_done(1);
      e_v = expq.pop_front();
      `CHK({pslverr, prdata}, e_v)
    end
  end
  initial begin
    presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 8'h00;
    pwdata = 32'h0; closed_loop = 0; open_loop = 0; above_handoff = 0;
    kt_learn = 0; kt_live_valid = 0; short_circuit_threshold = 0;
    turning = 1; period = 16'h00C8; bemf_integral = 16'h0;
    kt_live = 16'h0; speed = 16'h0; speed_cmd = 16'h0;
    motor_resistance = 16'h0;
    void'($urandom(87));
    repeat (5) @(posedge pclk);
    // Top bit set keeps the buffered command well above the soft limit.
    presetn <= 1'b1; speed <= 16'($urandom);
    speed_cmd <= 16'h8000 | 16'($urandom);
    motor_resistance <= 16'($urandom); adv = 5'($urandom) | 5'h01;
    repeat (2) @(posedge pclk);
    `CHK(drive_en, 1'b1)
    apb(0, 8'h04, 0, {1'b0, 32'h64});
    apb(0, 8'h08, 0, {1'b0, 32'hFA0});
    apb(0, 8'h1C, 0, {1'b1, 32'h0});
    apb(1, 8'h00, {24'h0, adv, 3'h0}, 0);
    apb(0, 8'h00, 0, {1'b0, 24'h0, adv, 3'h0});
    apb(1, 8'h08, 32'hA, 0);
    apb(1, 8'h10, 32'h1, 0);
    // Fast ticks in closed loop look like a stalled, racing loop.
    closed_loop <= 1'b1; period <= 16'h0014;
    `WAITC(!drive_en)
    t0 = $time;
    `CHK(low_side_switch, 1'b1)
    closed_loop <= 1'b0; period <= 16'h00C8;
    `WAITC(irq)
    `CHK(amplitude, 16'h0000)
    apb(0, 8'h0C, 0, {1'b0, 32'h1});
    `WAITC(restart_req)
    `CHK(($time - t0) / 20 >= 13000 && ($time - t0) / 20 <= 15100, 1)
    @(posedge pclk);
    `CHK(drive_en, 1'b1)
    apb(1, 8'h0C, 32'h1, 0);
    `WAITC(!irq)
    apb(0, 8'h0C, 0, {1'b0, 32'h0});
    // Open loop with crossings present must keep running.
    open_loop <= 1'b1; above_handoff <= 1'b1;
    repeat (2000) @(posedge pclk);
    `CHK(drive_en, 1'b1)
    turning <= 1'b0;
    `WAITC(!drive_en)
    open_loop <= 1'b0; turning <= 1'b1;
    apb(0, 8'h0C, 0, {1'b0, 32'h8});
    `CHK(irq, 1'b0)
    `WAITC(restart_req)
    apb(1, 8'h0C, 32'h8, 0);
    short_circuit_threshold <= 1'b1;
    repeat (2) @(posedge pclk);
    `CHK({drive_en, low_side_switch}, 2'b00)
    short_circuit_threshold <= 1'b0;
    `WAITC(init_req)
    @(posedge pclk);
    `CHK(drive_en, 1'b1)
    apb(0, 8'h0C, 0, {1'b0, 32'h10});
    // No constant learned yet, so the clamp is only the resistive drop.
    motor_resistance <= 16'h0100;
    closed_loop <= 1'b1;
    apb(1, 8'h00, {24'h0, adv, 3'h1}, 0);
    repeat (3) @(posedge pclk);
    `CHK(amplitude, 16'h007D)
    `CHK(drive_en, 1'b1)
    apb(0, 8'h0C, 0, {1'b0, 32'h30});
    apb(1, 8'h00, {24'h0, adv, 3'h0}, 0);
    repeat (2) @(posedge pclk);
    `CHK(amplitude > 16'h007D, 1'b1)
    // Crossings closer than one step fire the advance right after arming.
    repeat (600) @(posedge pclk);
    `WAITC(zero_cross)
    repeat (2) @(posedge pclk);
    `CHK(comm_advance, 1'b1)
    @(posedge pclk);
    `CHK(comm_advance, 1'b0)
    // Learn a constant, then report a live one far above its bound.
    speed <= 16'hFFFF;
    bemf_integral <= 16'h0100;
    kt_learn <= 1'b1;
    @(posedge pclk);
    kt_learn <= 1'b0;
    apb(0, 8'h18, 0, {1'b0, 32'h0140_0100});
    kt_live <= 16'h0200;
    kt_live_valid <= 1'b1;
    @(posedge pclk);
    kt_live_valid <= 1'b0;
    `WAITC(!drive_en)
    apb(0, 8'h0C, 0, {1'b0, 32'h32});
    // Full-scale back-EMF now outruns demand; a short qualification locks.
    apb(1, 8'h04, 32'h2, 0);
    `WAITC(restart_req)
    @(posedge pclk);
    `CHK(amplitude, 16'hFFFF)
    `WAITC(!drive_en)
    apb(0, 8'h0C, 0, {1'b0, 32'h36});
    test_done(0);
  end
endmodule
